// ---- cae_defs.svh ----
`ifndef CAE_DEFS_SVH
`define CAE_DEFS_SVH
// Angles are signed fixed point in tenths of a degree.
`define CAE_ANG_W      14
`define CAE_RES_W      16
`define CAE_CNT_W      8
`define CAE_FULL_TURN  14'sh1C20
`define CAE_ZERO_ANG   14'sh0000
`define CAE_ZERO_RES   16'sh0000
`define CAE_ONE_RES    16'sh0001
`define CAE_ZERO_CNT   8'h00
`define CAE_ONE_CNT    8'h01
`endif

// ---- cae_pkg.sv ----
`default_nettype none
package cae_pkg;
  typedef enum logic [1:0] {
    CAE_TO_OFF    = 2'h0,
    CAE_TO_INPDEP = 2'h1,
    CAE_TO_PREDEF = 2'h2
  } cae_to_mode_t;
  typedef enum logic [2:0] {
    CAE_ST_IDLE  = 3'h1,
    CAE_ST_CALC  = 3'h2,
    CAE_ST_WRITE = 3'h4
  } cae_state_t;
endpackage : cae_pkg
`default_nettype wire

// ---- cae_if.sv ----
`default_nettype none
`include "cae_defs.svh"
interface cae_if;
  logic                          check;
  cae_pkg::cae_to_mode_t         mode;
  logic                          got_result;
  logic                          level_active;
  logic signed [`CAE_RES_W-1:0]  default_value;
  logic                          fire;
  logic signed [`CAE_RES_W-1:0]  value;
  modport owner (output check, output mode, output got_result, output level_active,
                 output default_value, input fire, input value);
  modport mon (input check, input mode, input got_result, input level_active,
               input default_value, output fire, output value);
endinterface : cae_if
`default_nettype wire

// ---- cae_timeout.sv ----
`default_nettype none
`include "cae_defs.svh"
module cae_timeout (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic clk_en,
  cae_if.mon        tio
);
  logic                         seen_q, seen_d;
  logic                         fire_q, fire_d;
  logic signed [`CAE_RES_W-1:0] value_q, value_d;

  always_comb begin
    seen_d  = seen_q;
    fire_d  = 1'b0;
    value_d = value_q;
    if (tio.check) begin
      // A result landing in the check cycle counts, so the check sees it and clears.
      if (!seen_q && !tio.got_result && tio.mode != cae_pkg::CAE_TO_OFF) begin
        fire_d = 1'b1;
        if (tio.mode == cae_pkg::CAE_TO_INPDEP) begin
          value_d = tio.level_active ? `CAE_ONE_RES : `CAE_ZERO_RES;
        end else begin
          value_d = tio.default_value;
        end
      end
      seen_d = 1'b0;
    end else if (tio.got_result) begin
      seen_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      seen_q  <= 1'b0;
      fire_q  <= 1'b0;
      value_q <= `CAE_ZERO_RES;
    end else if (clk_en) begin
      seen_q  <= seen_d;
      fire_q  <= fire_d;
      value_q <= value_d;
    end
  end

  assign tio.fire  = fire_q;
  assign tio.value = value_q;

  timeout_fire_a: assert property (@(posedge ref_clk) disable iff (srst)
    (clk_en && tio.check && !seen_q && !tio.got_result && tio.mode != cae_pkg::CAE_TO_OFF)
    |=> tio.fire) else $error("timeout not declared");
  no_fire_a: assert property (@(posedge ref_clk) disable iff (srst)
    (clk_en && tio.check && seen_q) |=> !tio.fire) else $error("spurious timeout");
endmodule : cae_timeout
`default_nettype wire

// ---- cae_capture.sv ----
`default_nettype none
`include "cae_defs.svh"
module cae_capture (
  input  wire logic                         ref_clk,
  input  wire logic                         srst,
  input  wire logic                         clk_en,
  input  wire logic                         sig_in,
  input  wire logic                         falling_sel,
  input  wire logic                         speed_sync,
  input  wire logic                         edge_selective,
  input  wire logic [`CAE_CNT_W-1:0]        edge_number,
  input  wire logic [`CAE_ANG_W-1:0]        crank_angle,
  input  wire logic signed [`CAE_ANG_W-1:0] window_lower_bound,
  input  wire logic signed [`CAE_ANG_W-1:0] window_upper_bound,
  input  wire logic signed [`CAE_ANG_W-1:0] reference_angle,
  input  wire logic                         timeout_check,
  input  wire cae_pkg::cae_to_mode_t        crank_timeout_mode,
  input  wire logic signed [`CAE_RES_W-1:0] crank_timeout_default,
  input  wire logic                         ena_result_valid,
  input  wire logic signed [`CAE_RES_W-1:0] ena_result,
  input  wire logic                         ena_level_active,
  input  wire cae_pkg::cae_to_mode_t        ena_timeout_mode,
  input  wire logic signed [`CAE_RES_W-1:0] ena_timeout_default,
  output logic signed [`CAE_RES_W-1:0]      angle_result,
  output logic                              angle_new,
  output logic                              angle_timeout,
  output logic signed [`CAE_RES_W-1:0]      ena_host_value,
  output logic                              ena_host_write,
  output logic                              ena_timeout
);
  cae_if ang_to ();
  cae_if ena_to ();

  logic                         sig_q, sig_d;
  logic [`CAE_CNT_W-1:0]        cnt_q, cnt_d;
  logic                         below_q, below_d;
  cae_pkg::cae_state_t          st_q, st_d;
  logic signed [`CAE_ANG_W:0]   map_q, map_d;
  logic signed [`CAE_RES_W-1:0] ares_q, ares_d;
  logic                         anew_q, anew_d;
  logic                         ato_q, ato_d;
  logic signed [`CAE_RES_W-1:0] eval_q, eval_d;
  logic                         ewr_q, ewr_d;
  logic                         eto_q, eto_d;

  logic                         act_edge;
  logic signed [`CAE_ANG_W:0]   ang_s;
  logic signed [`CAE_ANG_W:0]   lwl_s;
  logic signed [`CAE_ANG_W:0]   upr_s;
  logic signed [`CAE_ANG_W:0]   turn_s;
  logic signed [`CAE_ANG_W:0]   map_now;
  logic                         in_window;
  logic                         below_now;
  logic [`CAE_CNT_W-1:0]        cnt_inc;
  logic                         take;

  always_comb begin
    act_edge  = falling_sel ? (sig_q && !sig_in) : (!sig_q && sig_in);
    // Incoming angle at or above a turn has one turn taken off, so only inputs below two turns end below 7200.
    ang_s     = (crank_angle >= `CAE_FULL_TURN) ?
                {1'b0, crank_angle - `CAE_FULL_TURN} : {1'b0, crank_angle};
    lwl_s     = {window_lower_bound[`CAE_ANG_W-1], window_lower_bound};
    upr_s     = {window_upper_bound[`CAE_ANG_W-1], window_upper_bound};
    // Held in a signed variable so that comparisons against it stay signed.
    turn_s    = {1'b0, `CAE_FULL_TURN};
    map_now   = ang_s;
    if (speed_sync && ang_s < lwl_s) begin
      map_now = ang_s + turn_s;
    end else if (speed_sync && ang_s >= lwl_s + turn_s) begin
      map_now = ang_s - turn_s;
    end
    below_now = ang_s < lwl_s;
    // The window is judged on the mapped angle, which never lies below the lower bound.
    in_window = map_now <= upr_s;
    cnt_inc   = cnt_q + `CAE_ONE_CNT;
    // Selective with number zero degrades to non-selective.
    take      = !edge_selective || (edge_number == `CAE_ZERO_CNT) ||
                (cnt_inc == edge_number);
  end

  always_comb begin
    sig_d   = sig_in;
    cnt_d   = cnt_q;
    below_d = below_now;
    st_d    = st_q;
    map_d   = map_q;
    ares_d  = ares_q;
    anew_d  = 1'b0;
    if (speed_sync && below_now && !below_q) begin
      cnt_d = `CAE_ZERO_CNT;
    end
    case (st_q)
      cae_pkg::CAE_ST_IDLE: begin
        if (act_edge && (!speed_sync || in_window)) begin
          if (cnt_q != {`CAE_CNT_W{1'b1}}) begin
            cnt_d = cnt_inc;
          end
          if (take) begin
            st_d  = cae_pkg::CAE_ST_CALC;
            map_d = map_now;
          end
        end
      end
      cae_pkg::CAE_ST_CALC: begin
        ares_d = 16'(reference_angle) - 16'(map_q);
        st_d   = cae_pkg::CAE_ST_WRITE;
      end
      cae_pkg::CAE_ST_WRITE: begin
        anew_d = 1'b1;
        st_d   = cae_pkg::CAE_ST_IDLE;
      end
      default: begin
        st_d = cae_pkg::CAE_ST_IDLE;
      end
    endcase
  end

  // Edges arriving while a result is computed are lost; the window is two cycles.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sig_q   <= 1'b0;
      cnt_q   <= `CAE_ZERO_CNT;
      below_q <= 1'b0;
      st_q    <= cae_pkg::CAE_ST_IDLE;
      map_q   <= '0;
      ares_q  <= `CAE_ZERO_RES;
      anew_q  <= 1'b0;
    end else if (clk_en) begin
      sig_q   <= sig_d;
      cnt_q   <= cnt_d;
      below_q <= below_d;
      st_q    <= st_d;
      map_q   <= map_d;
      ares_q  <= ares_d;
      anew_q  <= anew_d;
    end
  end

  assign ang_to.check         = timeout_check;
  assign ang_to.mode          = crank_timeout_mode;
  assign ang_to.got_result    = anew_q;
  assign ang_to.level_active  = falling_sel ? !sig_q : sig_q;
  assign ang_to.default_value = crank_timeout_default;
  assign ena_to.check         = timeout_check;
  assign ena_to.mode          = ena_timeout_mode;
  assign ena_to.got_result    = ena_result_valid;
  assign ena_to.level_active  = ena_level_active;
  assign ena_to.default_value = ena_timeout_default;

  cae_timeout u_ang_to (
    .ref_clk (ref_clk),
    .srst    (srst),
    .clk_en  (clk_en),
    .tio     (ang_to.mon)
  );
  cae_timeout u_ena_to (
    .ref_clk (ref_clk),
    .srst    (srst),
    .clk_en  (clk_en),
    .tio     (ena_to.mon)
  );

  always_comb begin
    ato_d  = ang_to.fire;
    eto_d  = ena_to.fire;
    eval_d = eval_q;
    ewr_d  = 1'b0;
    if (ena_result_valid) begin
      eval_d = ena_result;
      ewr_d  = 1'b1;
    end else if (ena_to.fire) begin
      eval_d = ena_to.value;
      ewr_d  = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ato_q  <= 1'b0;
      eto_q  <= 1'b0;
      eval_q <= `CAE_ZERO_RES;
      ewr_q  <= 1'b0;
    end else if (clk_en) begin
      ato_q  <= ato_d;
      eto_q  <= eto_d;
      eval_q <= eval_d;
      ewr_q  <= ewr_d;
    end
  end

  // Angle output register takes a fresh result or a timeout value.
  logic signed [`CAE_RES_W-1:0] aout_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aout_q <= `CAE_ZERO_RES;
    end else if (clk_en) begin
      aout_q <= anew_q ? ares_q : (ang_to.fire ? ang_to.value : aout_q);
    end
  end

  assign angle_result   = aout_q;
  assign angle_new      = anew_q;
  assign angle_timeout  = ato_q;
  assign ena_host_value = eval_q;
  assign ena_host_write = ewr_q;
  assign ena_timeout    = eto_q;

  counter_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
    (clk_en && speed_sync && below_now && !below_q && (st_q != cae_pkg::CAE_ST_IDLE || !act_edge))
    |=> cnt_q == `CAE_ZERO_CNT) else $error("edge counter not cleared");
  edge_take_a: assert property (@(posedge ref_clk) disable iff (srst)
    (clk_en && st_q == cae_pkg::CAE_ST_IDLE && act_edge && in_window && take)
    ##1 clk_en [*2] |=> angle_new) else $error("edge result missing");
  diff_value_a: assert property (@(posedge ref_clk) disable iff (srst)
    (clk_en && st_q == cae_pkg::CAE_ST_CALC)
    |=> ares_q == 16'(reference_angle) - 16'(map_q)) else $error("bad difference");
  map_range_a: assert property (@(posedge ref_clk) disable iff (srst)
    (st_q == cae_pkg::CAE_ST_CALC && speed_sync) |-> map_q >= lwl_s)
    else $error("angle not remapped");
  async_map_a: assert property (@(posedge ref_clk) disable iff (srst)
    (st_q == cae_pkg::CAE_ST_CALC && !speed_sync)
    |-> map_q < {1'b0, `CAE_FULL_TURN}) else $error("async angle altered");
  sel_skip_a: assert property (@(posedge ref_clk) disable iff (srst)
    (clk_en && st_q == cae_pkg::CAE_ST_IDLE && act_edge && edge_selective
     && edge_number != `CAE_ZERO_CNT && cnt_inc != edge_number)
    |=> st_q == cae_pkg::CAE_ST_IDLE) else $error("wrong edge selected");
  ena_forward_a: assert property (@(posedge ref_clk) disable iff (srst)
    (clk_en && ena_result_valid) |=> ena_host_write && ena_host_value == $past(ena_result))
    else $error("enable result not forwarded");
  new_pulse_a: assert property (@(posedge ref_clk) disable iff (srst)
    (clk_en && angle_new) |=> !angle_new)
    else $error("new strobe out of sequence");
endmodule : cae_capture
`default_nettype wire

// ---- cae_src.sv ----
`default_nettype none
`include "cae_defs.svh"
// Far side: the measured channel and the crank angle source, driven at the falling clock edge.
module cae_src (
  input  wire logic                  ref_clk,
  output logic                       sig,
  output logic [`CAE_ANG_W-1:0]      ang
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sig = 1'b0;
    ang = '0;
  end
  task automatic drive(input int a, input logic lvl);
    @(negedge ref_clk);
    ang = 14'(((a % 7200) + 7200) % 7200);
    sig = lvl;
  endtask : drive
endmodule : cae_src
`default_nettype wire

// ---- cae_capture_tb_top.sv ----
`default_nettype none
`include "cae_defs.svh"
module cae_capture_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                           ref_clk, srst, sig_in, falling_sel, speed_sync, clk_en;
  int                             n_hold;
  logic                           edge_selective, timeout_check, ena_result_valid;
  logic                           ena_level_active, angle_new, angle_timeout;
  logic                           ena_host_write, ena_timeout;
  logic [`CAE_CNT_W-1:0]          edge_number;
  logic [`CAE_ANG_W-1:0]          crank_angle;
  logic signed [`CAE_RES_W-1:0]   ena_result, angle_result, ena_host_value;
  logic signed [`CAE_RES_W-1:0]   crank_timeout_default, ena_timeout_default;
  cae_pkg::cae_to_mode_t          crank_timeout_mode, ena_timeout_mode;
  int                             lwl_i, upr_i, rf_i, error_cnt, check_count, cyc;
  int                             n_new, n_ato, n_eto, n_ew;
  logic                           ang_got, ena_got;

  cae_src u_cae_src (.ref_clk(ref_clk), .sig(sig_in), .ang(crank_angle));
  cae_capture u_cae_capture (
    .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .sig_in(sig_in),
    .falling_sel(falling_sel), .speed_sync(speed_sync), .edge_selective(edge_selective),
    .edge_number(edge_number), .crank_angle(crank_angle),
    .window_lower_bound(14'(lwl_i)), .window_upper_bound(14'(upr_i)),
    .reference_angle(14'(rf_i)), .timeout_check(timeout_check),
    .crank_timeout_mode(crank_timeout_mode), .crank_timeout_default(crank_timeout_default),
    .ena_result_valid(ena_result_valid), .ena_result(ena_result),
    .ena_level_active(ena_level_active), .ena_timeout_mode(ena_timeout_mode),
    .ena_timeout_default(ena_timeout_default), .angle_result(angle_result),
    .angle_new(angle_new), .angle_timeout(angle_timeout), .ena_host_value(ena_host_value),
    .ena_host_write(ena_host_write), .ena_timeout(ena_timeout));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Pulse counters let a task see a one-cycle output without racing the edge.
  always @(posedge ref_clk) begin
    n_new += int'(angle_new === 1'b1);
    n_ato += int'(angle_timeout === 1'b1);
    n_eto += int'(ena_timeout === 1'b1);
    n_ew += int'(ena_host_write === 1'b1);
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic signed [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask : chk

  function automatic int exp_res(input int a);
    int m;
    m = a;
    if (speed_sync && m < lwl_i) m += 7200;
    if (speed_sync && m >= lwl_i + 7200) m -= 7200;
    return rf_i - m;
  endfunction : exp_res

  // Inactive level first, so the next drive is one active edge at angle a.
  task automatic edge_at(input int a, input logic hit);
    int n0;
    u_cae_src.drive(a, falling_sel);
    repeat (3) @(negedge ref_clk);
    n0 = n_new;
    u_cae_src.drive(a, !falling_sel);
    repeat (6) @(negedge ref_clk);
    chk("angle_new count", 16'(n_new - n0), {15'h0000, hit});
    if (hit) chk("angle_result", angle_result, 16'(exp_res(a)));
    if (hit) ang_got = 1'b1;
  endtask : edge_at

  task automatic tcheck(input logic signed [15:0] aexp, eexp);
    int a0, e0;
    a0 = n_ato;
    e0 = n_eto;
    @(negedge ref_clk);
    timeout_check = 1'b1;
    @(negedge ref_clk);
    timeout_check = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("angle_timeout count", 16'(n_ato - a0), {15'h0000, !ang_got});
    if (!ang_got) chk("angle_result", angle_result, aexp);
    chk("ena_timeout count", 16'(n_eto - e0), {15'h0000, !ena_got});
    if (!ena_got) chk("ena_host_value", ena_host_value, eexp);
    ang_got = 1'b0;
    ena_got = 1'b0;
  endtask : tcheck

  task automatic ena_put(input logic signed [15:0] v);
    int w0;
    w0 = n_ew;
    @(negedge ref_clk);
    ena_result = v;
    ena_result_valid = 1'b1;
    @(negedge ref_clk);
    ena_result_valid = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("ena_host_write count", 16'(n_ew - w0), 16'h0001);
    chk("ena_host_value", ena_host_value, v);
    ena_got = 1'b1;
  endtask : ena_put

  task automatic conclude();
    $display("Checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  initial begin
    {srst, falling_sel, speed_sync, edge_selective, timeout_check} = 5'h10;
    {ena_result_valid, ena_level_active, ang_got, ena_got} = 4'h0;
    clk_en = 1'b1;
    {edge_number, ena_result} = '0;
    {lwl_i, upr_i, rf_i, error_cnt, check_count, cyc, n_new, n_ato, n_eto, n_ew} = '0;
    crank_timeout_mode = cae_pkg::CAE_TO_PREDEF;
    ena_timeout_mode = cae_pkg::CAE_TO_PREDEF;
    crank_timeout_default = -16'sh007B;
    ena_timeout_default = 16'sh0159;
    repeat (12) @(negedge ref_clk);
    srst = 1'b0;
    for (int p = 0; p < 2; p++) begin
      falling_sel = p[0];
      rf_i = -7200;
      edge_at(0, 1'b1);
      edge_at(7199, 1'b1);
      rf_i = 7200;
      edge_at(0, 1'b1);
    end
    $display("test async done");
    {speed_sync, falling_sel, lwl_i, upr_i} = {1'b1, 1'b0, 32'd1000, 32'd5000};
    edge_at(2000, 1'b1);
    edge_at(6000, 1'b0);
    {lwl_i, upr_i, rf_i} = {-32'sd1000, 32'd2000, -32'sd7200};
    edge_at(6500, 1'b1);
    edge_at(3000, 1'b0);
    $display("test window done");
    {lwl_i, upr_i, edge_selective, edge_number} = {32'd1000, 32'd5000, 1'b1, 8'h02};
    for (int w = 0; w < 2; w++) begin
      u_cae_src.drive(500, 1'b0);
      repeat (4) @(negedge ref_clk);
      edge_at(2000, 1'b0);
      edge_at(2500, 1'b1);
      edge_at(3000, 1'b0);
    end
    edge_number = 8'h00;
    edge_at(3500, 1'b1);
    edge_at(4000, 1'b1);
    // With the enable low the edge waits and is taken once the enable returns.
    u_cae_src.drive(4000, 1'b0);
    repeat (3) @(negedge ref_clk);
    n_hold = n_new;
    clk_en = 1'b0;
    u_cae_src.drive(4200, 1'b1);
    repeat (6) @(negedge ref_clk);
    chk("frozen angle_new count", 16'(n_new - n_hold), 16'h0000);
    clk_en = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk("resumed angle_new count", 16'(n_new - n_hold), 16'h0001);
    ang_got = 1'b1;
    $display("test selective done");
    tcheck(-16'sh007B, 16'sh0159);
    tcheck(-16'sh007B, 16'sh0159);
    edge_at(2000, 1'b1);
    ena_put(-16'sh0222);
    tcheck(16'sh0000, 16'sh0000);
    crank_timeout_mode = cae_pkg::CAE_TO_INPDEP;
    ena_timeout_mode = cae_pkg::CAE_TO_INPDEP;
    ena_level_active = 1'b1;
    tcheck(16'sh0001, 16'sh0001);
    {falling_sel, ena_level_active} = 2'h2;
    tcheck(16'sh0000, 16'sh0000);
    $display("test timeout done");
    srst = 1'b1;
    // Channel goes to its inactive level during reset so no false edge follows release.
    u_cae_src.drive(0, 1'b0);
    {srst, speed_sync, falling_sel, edge_number} = {1'b0, 1'b0, 1'b0, 8'h02};
    chk("angle_result after reset", angle_result, 16'sh0000);
    edge_at(100, 1'b0);
    edge_at(200, 1'b1);
    edge_at(300, 1'b0);
    u_cae_src.drive(50, 1'b0);
    edge_at(400, 1'b0);
    $display("test async selective done");
    conclude();
  end
endmodule : cae_capture_tb_top
`default_nettype wire
